// ### hw/mss_pkg.sv
// constants, types and register map of the motor status register bank
// assumes one 125 mhz clock and a synchronous active-high reset
package mss_pkg;
	// ==========================================================
	// register map
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFF_SUPPLY_SPEED = 8'he4;
	localparam logic [7:0] OFF_ALGO_CTRL = 8'he6;
	localparam logic [7:0] OFF_STATE_RATE = 8'hea;
	localparam logic [7:0] OFF_CURR_POWER = 8'hec;
	localparam logic [7:0] OFF_IRQ_STATUS = 8'hf0;
	localparam logic [7:0] OFF_IRQ_MASK = 8'hf2;
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;
	// ==========================================================
	// field positions
	localparam int VOLT_LSB = 16;
	localparam int SPEED_REQ_LSB = 1;
	localparam int SERIAL_ENTRY_BIT = 0;
	localparam int STATE_LSB = 28;
	localparam int SELFTEST_BIT = 17;
	localparam int RATE_LSB = 0;
	localparam int CURR_LSB = 16;
	localparam int POWER_LSB = 0;
	// ==========================================================
	// interrupt event bits
	localparam int EV_W = 4;
	localparam int EV_STATE = 0;
	localparam int EV_SELFTEST = 1;
	localparam int EV_FAULT = 2;
	localparam int EV_SERIAL = 3;
	// ==========================================================
	// control state codes
	typedef enum logic [3:0] {
		CS_SYSTEM_IDLE = 4'h0,
		CS_START = 4'h1,
		CS_RUN = 4'h2,
		CS_INIT = 4'h3,
		CS_INITIAL_POSITION_DETECT = 4'h4,
		CS_ALIGN = 4'h5,
		CS_MOTOR_IDLE = 4'h6,
		CS_STOP = 4'h7,
		CS_FAULT = 4'h8,
		CS_DIRECTION = 4'h9,
		CS_SENSOR_ALIGNMENT = 4'ha,
		CS_COASTING = 4'hc,
		CS_BRAKE = 4'hd,
		CS_NOT_APPLICABLE = 4'hf
	} mss_state_code_t;
	// snapshot of the measurements presented to the bank
	typedef struct packed {
		logic [15:0] supply_voltage_reading;
		logic [14:0] speed_request;
		logic serial_entry;
		logic [3:0] state_code;
		logic selftest_failure_flag;
		logic [15:0] electrical_speed;
		logic [15:0] bus_current_reading;
		logic [15:0] input_power_reading;
	} mss_meas_t;
endpackage

// ### hw/mss_meas_if.sv
// measurement carrier between the capture stage and the register bank
// assumes the capture stage and bank share one clock
`timescale 1ns/1ns
interface mss_meas_if;
	mss_pkg::mss_meas_t meas;
	logic [mss_pkg::EV_W-1:0] events;
	modport producer (output meas, output events);
	modport consumer (input meas, input events);
endinterface

// ### hw/mss_capture.sv
// registers the live measurements and detects status events
// assumes inputs synchronous to clock
`timescale 1ns/1ns
module mss_capture (
	input wire logic clock, // system clock
	input wire logic sys_rst, // synchronous reset, high
	input wire mss_pkg::mss_meas_t live, // live measurements
	mss_meas_if.producer out // registered snapshot and events
);
	mss_pkg::mss_meas_t meas_q;
	logic [mss_pkg::EV_W-1:0] ev_q;
	logic [mss_pkg::EV_W-1:0] ev_d;
	logic fault_now;

	// ==========================================================
	// event detection against the previous snapshot
	assign fault_now = (live.state_code == mss_pkg::CS_FAULT);
	assign ev_d[mss_pkg::EV_STATE] = live.state_code != meas_q.state_code;
	assign ev_d[mss_pkg::EV_SELFTEST] = live.selftest_failure_flag
		& ~meas_q.selftest_failure_flag;
	assign ev_d[mss_pkg::EV_FAULT] = fault_now
		& (meas_q.state_code != mss_pkg::CS_FAULT);
	assign ev_d[mss_pkg::EV_SERIAL] = live.serial_entry
		& ~meas_q.serial_entry;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			meas_q <= '0;
			ev_q <= '0;
		end else begin
			meas_q <= live;
			ev_q <= ev_d;
		end
	end

	assign out.meas = meas_q;
	assign out.events = ev_q;
endmodule

// ### hw/mss_regs.sv
// motor status register bank, read-only except the writable interrupt mask, with interrupt status
// assumes a simple strobe port: read data valid the cycle after rd_stb
// What this block does
// - supply voltage tenths volt, upper word
// - 15-bit speed request at bits 15:1
// - bit 0 flags serial entry via pins
// - control state code in bits 31:28
// - state codes per fixed enumeration
// - self-test failure at bit 17
// - electrical speed tenths hertz, low word
// - bus current 1/256 amp, upper word
// - input power 1/64 watt, low word
//
// Our own choice: strobed register access.
`timescale 1ns/1ns
module mss_regs (
	input wire logic clock, // system clock 125 mhz
	input wire logic sys_rst, // synchronous reset, high
	input wire logic [mss_pkg::ADDR_W-1:0] addr, // register offset
	input wire logic [31:0] wdata, // write data
	input wire logic wr_stb, // write strobe
	input wire logic rd_stb, // read strobe
	output logic [31:0] rdata, // read data, cycle after rd_stb
	output logic irq, // level interrupt
	input wire logic [15:0] supply_voltage_reading, // tenths of volt
	input wire logic [14:0] speed_request, // 32767 is full scale
	input wire logic serial_entry, // serial mode entered by pins
	input wire logic [3:0] state_code, // control state code
	input wire logic selftest_failure_flag, // self-test failed
	input wire logic [15:0] electrical_speed, // tenths of hertz
	input wire logic [15:0] bus_current_reading, // 1/256 ampere
	input wire logic [15:0] input_power_reading // 1/64 watt
);
	mss_pkg::mss_meas_t live;
	mss_meas_if meas_bus ();
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic irq_q;
	logic irq_d;
	logic [mss_pkg::EV_W-1:0] stat_q;
	logic [mss_pkg::EV_W-1:0] stat_d;
	logic [mss_pkg::EV_W-1:0] mask_q;
	logic [mss_pkg::EV_W-1:0] mask_d;
	logic [31:0] word_supply;
	logic [31:0] word_state;
	logic [31:0] word_curr;
	logic [31:0] word_stat;
	logic [31:0] word_mask;
	logic sel_supply;
	logic sel_state;
	logic sel_curr;
	logic sel_stat;
	logic sel_mask;
	logic stat_rd;
	logic mask_wr;

	// ==========================================================
	// measurement capture
	assign live.supply_voltage_reading = supply_voltage_reading;
	assign live.speed_request = speed_request;
	assign live.serial_entry = serial_entry;
	assign live.state_code = state_code;
	assign live.selftest_failure_flag = selftest_failure_flag;
	assign live.electrical_speed = electrical_speed;
	assign live.bus_current_reading = bus_current_reading;
	assign live.input_power_reading = input_power_reading;

	mss_capture u_capture (
		.clock(clock),
		.sys_rst(sys_rst),
		.live(live),
		.out(meas_bus)
	);

	// ==========================================================
	// address decode
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	assign sel_supply = hit(addr, mss_pkg::OFF_SUPPLY_SPEED);
	assign sel_state = hit(addr, mss_pkg::OFF_STATE_RATE);
	assign sel_curr = hit(addr, mss_pkg::OFF_CURR_POWER);
	assign sel_stat = hit(addr, mss_pkg::OFF_IRQ_STATUS);
	assign sel_mask = hit(addr, mss_pkg::OFF_IRQ_MASK);
	assign stat_rd = rd_stb & sel_stat;
	// status words have no write path; only the mask takes writes
	assign mask_wr = wr_stb & sel_mask;

	// ==========================================================
	// status word assembly, unused positions stay zero
	always_comb begin
		word_supply = '0;
		word_supply[mss_pkg::VOLT_LSB +: 16] =
			meas_bus.meas.supply_voltage_reading;
		word_supply[mss_pkg::SPEED_REQ_LSB +: 15] =
			meas_bus.meas.speed_request;
		word_supply[mss_pkg::SERIAL_ENTRY_BIT] =
			meas_bus.meas.serial_entry;
	end

	always_comb begin
		word_state = '0;
		// code passed through unchanged, so every listed code reads as is
		word_state[mss_pkg::STATE_LSB +: 4] =
			meas_bus.meas.state_code;
		word_state[mss_pkg::SELFTEST_BIT] =
			meas_bus.meas.selftest_failure_flag;
		word_state[mss_pkg::RATE_LSB +: 16] =
			meas_bus.meas.electrical_speed;
	end

	always_comb begin
		word_curr = '0;
		word_curr[mss_pkg::CURR_LSB +: 16] =
			meas_bus.meas.bus_current_reading;
		word_curr[mss_pkg::POWER_LSB +: 16] =
			meas_bus.meas.input_power_reading;
	end

	assign word_stat = {{(32-mss_pkg::EV_W){1'b0}}, stat_q};
	assign word_mask = {{(32-mss_pkg::EV_W){1'b0}}, mask_q};

	// ==========================================================
	// read mux; unmapped offsets, the undecoded control word offset 8'he6 and
	// reserved holes all answer zero
	assign rdata_d = !rd_stb ? mss_pkg::RESET_WORD :
		sel_supply ? word_supply :
		sel_state ? word_state :
		sel_curr ? word_curr :
		sel_stat ? word_stat :
		sel_mask ? word_mask :
		mss_pkg::RESET_WORD;

	// ==========================================================
	// interrupts: read clears, a same-cycle event still lands
	assign stat_d = (stat_rd ? '0 : stat_q) | meas_bus.events;
	assign mask_d = mask_wr ? wdata[mss_pkg::EV_W-1:0] : mask_q;
	assign irq_d = |(stat_d & mask_d);

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			rdata_q <= mss_pkg::RESET_WORD;
			stat_q <= '0;
			mask_q <= '0;
			irq_q <= 1'b0;
		end else begin
			rdata_q <= rdata_d;
			stat_q <= stat_d;
			mask_q <= mask_d;
			irq_q <= irq_d;
		end
	end

	assign rdata = rdata_q;
	assign irq = irq_q;
endmodule

// ### testbench/mss_regs_chk.sv
// read-port assertions for the motor status bank
// assumes it is bound to the bank, one clock, synchronous reset
`timescale 1ns/1ns
module mss_regs_chk (
	input wire logic clock, // clock
	input wire logic sys_rst, // reset
	input wire logic [7:0] addr, // offset
	input wire logic rd_stb, // read
	input wire logic [31:0] rdata, // data
	input wire logic [15:0] supply_voltage_reading, // volt
	input wire logic [14:0] speed_request, // speed
	input wire logic serial_entry, // serial
	input wire logic [3:0] state_code, // state
	input wire logic selftest_failure_flag, // test
	input wire logic [15:0] electrical_speed, // rate
	input wire logic [15:0] bus_current_reading, // amps
	input wire logic [15:0] input_power_reading // watts
);
	// ==========
	// reads; the snapshot lags a cycle, so reads just after reset are skipped
	logic warm_q;
	wire rd_sys = rd_stb && addr == 8'he4 && warm_q;
	wire rd_st = rd_stb && addr == 8'hea && warm_q;
	wire rd_pw = rd_stb && addr == 8'hec && warm_q;
	always_ff @(posedge clock) warm_q <= !sys_rst;
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);
	a_volt_field: assert property (rd_sys |=>
		rdata[31:16] == $past(supply_voltage_reading, 2)) else $error("volt");
	a_speed_req: assert property (rd_sys |=>
		rdata[15:1] == $past(speed_request, 2)) else $error("speed");
	a_serial_flag: assert property (rd_sys |=>
		rdata[0] == $past(serial_entry, 2)) else $error("serial flag");
	a_state_code: assert property (rd_st |=>
		rdata[31:28] == $past(state_code, 2)) else $error("state code");
	a_selftest_flag: assert property (rd_st |=>
		rdata[17] == $past(selftest_failure_flag, 2)) else $error("selftest");
	a_rate_field: assert property (rd_st |=>
		rdata[15:0] == $past(electrical_speed, 2)) else $error("rate");
	a_curr_power: assert property (rd_pw |=> rdata ==
		{$past(bus_current_reading, 2), $past(input_power_reading, 2)})
		else $error("current or power");
	a_reserved_zero: assert property (rd_st |=>
		rdata[27:18] == 10'h000 && rdata[16] == 1'b0) else $error("reserved");
endmodule

bind mss_regs mss_regs_chk i_chk (.clock, .sys_rst, .addr, .rd_stb, .rdata,
	.supply_voltage_reading, .speed_request, .serial_entry, .state_code,
	.selftest_failure_flag, .electrical_speed, .bus_current_reading,
	.input_power_reading);

// ### testbench/motor_system_status_regs_tb_top.sv
// random and corner tests of the motor status register bank
// assumes the bank is instantiated here as i_dut and the checker is bound in
`timescale 1ns/1ns
module motor_system_status_regs_tb_top;
	logic clock = 1'b0, sys_rst = 1'b1, wr_stb = 1'b0, rd_stb = 1'b0, irq;
	logic ser = 1'b0, stf = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0] st = 4'h0;
	logic [14:0] sreq = 15'h0;
	logic [15:0] volt = 16'h0, spd = 16'h0, cur = 16'h0, pow = 16'h0;
	int failures = 0, n_checks = 0, seed = 32'he390;
	logic [3:0] codes [14] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6,
		4'h7, 4'h8, 4'h9, 4'ha, 4'hc, 4'hd, 4'hf};
	mss_regs i_dut (.clock, .sys_rst, .addr, .wdata, .wr_stb, .rd_stb, .rdata,
		.irq, .supply_voltage_reading(volt), .speed_request(sreq),
		.serial_entry(ser), .state_code(st), .selftest_failure_flag(stf),
		.electrical_speed(spd), .bus_current_reading(cur),
		.input_power_reading(pow));
	always #4 clock = ~clock;
	function logic [31:0] w_sys(); return {volt, sreq, ser}; endfunction
	function logic [31:0] w_st(); return {st, 10'h000, stf, 1'b0, spd}; endfunction
	// ==========
	// bus access; a read compares against d
	task chk(input string what, input logic [31:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic bus(input logic we, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr_stb <= we;
		rd_stb <= !we;
		@(posedge clock);
		{wr_stb, rd_stb} <= 2'b00;
		#1 if (!we) chk("rdata", rdata, d);
	endtask
	task report_and_stop;
		if (failures == 0 && n_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// ==========
	// main sequence
	initial begin
		static logic [7:0] offs [5] = '{8'he4, 8'hea, 8'hec, 8'hf0, 8'hf2};
		repeat (4) @(posedge clock);
		sys_rst <= 1'b0;
		foreach (offs[k]) bus(1'b0, offs[k], 32'h0);
		for (int i = 0; i < 14; i++) begin
			@(posedge clock);
			{volt, sreq, ser, stf, spd, cur, pow} <= i == 0 ? '1 :
				81'({$random(seed), $random(seed), $random(seed)});
			st <= codes[i];
			repeat (2) @(posedge clock);
			bus(1'b0, 8'he4, w_sys());
			bus(1'b0, 8'hea, w_st());
			bus(1'b0, 8'hec, {cur, pow});
			bus(1'b1, 8'hea, ~w_st());
			bus(1'b0, 8'hea, w_st());
			bus(1'b0, i[0] ? 8'he6 : 8'h7f, 32'h0);
		end
		// every event fired in the loop, so all four status bits are set
		@(posedge clock);
		{st, ser, stf} <= 6'h08;
		repeat (3) @(posedge clock);
		bus(1'b0, 8'hf0, 32'hf);
		bus(1'b1, 8'hf2, 32'h0);
		@(posedge clock);
		st <= 4'h3;
		repeat (3) @(posedge clock);
		#1 chk("irq", 32'(irq), 32'h0);
		bus(1'b1, 8'hf2, 32'h1);
		chk("irq", 32'(irq), 32'h1);
		bus(1'b0, 8'hf0, 32'h1);
		@(posedge clock);
		{st, ser, stf} <= 6'h23;
		#1 chk("irq", 32'(irq), 32'h0);
		bus(1'b1, 8'hf2, 32'hf);
		repeat (2) @(posedge clock);
		#1 chk("irq", 32'(irq), 32'h1);
		bus(1'b0, 8'hf0, 32'hf);
		chk("irq", 32'(irq), 32'h0);
		report_and_stop;
	end
	initial begin
		repeat (3000) @(posedge clock);
		failures++;
		report_and_stop;
	end
endmodule
